// ### logic/hotswap_fault_status_regs.sv
// Communication and vendor fault status registers of the hot-swap controller
`timescale 1ns/1ps
module hotswap_fault_status_regs (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // Register read port from the bus interface
    input wire logic rd_en,
    input wire logic [7:0] rd_cmd,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Clear of all status registers
    input wire logic clear_status,
    // Bus interface events, one-cycle pulses on this clock
    input wire logic bad_command_evt,
    input wire logic bad_payload_evt,
    input wire logic packet_check_evt,
    input wire logic misc_bus_evt,
    input wire logic trim_store_corrupt_evt,
    // Protection circuit levels, asynchronous to this clock
    input wire logic pass_health_pin,
    input wire logic short_circuit_pin,
    input wire logic current_limit_pin,
    input wire logic uv_comparator_pin,
    input wire logic ov_comparator_pin,
    input wire logic gate_request_pin,
    // Shutdown sequencer pulses, on this clock
    input wire logic overtemp_shutdown_evt,
    input wire logic timed_oc_shutdown_evt,
    input wire logic pass_health_shutdown_evt,
    input wire logic undervolt_shutdown_evt,
    input wire logic overvolt_shutdown_evt,
    // Gate drive permission toward the FET driver
    output logic gate_drive_en
);
    logic [hotswap_fault_pkg::PIN_COUNT-1:0] pins_raw; // Gathered pin levels
    logic [hotswap_fault_pkg::PIN_COUNT-1:0] pins_sync; // After two flops
    logic pass_health_live; // Synchronised health monitor level
    logic short_circuit_live; // Synchronised short circuit detector
    logic current_limit_live; // Synchronised limiting indicator
    logic undervoltage_comparator_live; // Synchronised UV comparator
    logic overvoltage_comparator_live; // Synchronised OV comparator
    logic gate_request_live; // Synchronised gate request
    logic [2:0] shutdown_reason_reg; // Last shutdown reason
    logic [2:0] shutdown_reason_next;
    logic [7:0] comm_memory_fault_status; // Assembled read value
    logic [7:0] vendor_fault_status; // Assembled read value
    logic [7:0] rd_data_next;
    logic gate_drive_next;
    logic any_shutdown; // Any shutdown pulse this cycle

    fault_flag_if #(.N(hotswap_fault_pkg::COMM_FLAG_COUNT)) comm_bus ();
    fault_flag_if #(.N(hotswap_fault_pkg::VENDOR_FLAG_COUNT)) vendor_bus ();

    // All protection levels cross into this domain together
    assign pins_raw = {gate_request_pin, ov_comparator_pin, uv_comparator_pin,
                       current_limit_pin, short_circuit_pin, pass_health_pin};

    sync2 #(.W(hotswap_fault_pkg::PIN_COUNT)) pin_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    assign pass_health_live = pins_sync[0];
    assign short_circuit_live = pins_sync[1];
    assign current_limit_live = pins_sync[2];
    assign undervoltage_comparator_live = pins_sync[3];
    assign overvoltage_comparator_live = pins_sync[4];
    assign gate_request_live = pins_sync[5];

    // Communication flag sets: command, payload, check, trim, misc
    assign comm_bus.set_evt = {bad_command_evt,
                               bad_payload_evt,
                               packet_check_evt,
                               trim_store_corrupt_evt,
                               misc_bus_evt};
    assign comm_bus.clear = clear_status;

    sticky_bank #(.N(hotswap_fault_pkg::COMM_FLAG_COUNT)) comm_flags (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .flag_bus(comm_bus)
    );

    // Vendor flag sets: health, short circuit, limiting; levels latch while high
    assign vendor_bus.set_evt = {pass_health_live,
                                 short_circuit_live,
                                 current_limit_live};
    assign vendor_bus.clear = clear_status;

    sticky_bank #(.N(hotswap_fault_pkg::VENDOR_FLAG_COUNT)) vendor_flags (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .flag_bus(vendor_bus)
    );

    assign any_shutdown = overtemp_shutdown_evt | timed_oc_shutdown_evt |
                          pass_health_shutdown_evt | undervolt_shutdown_evt |
                          overvolt_shutdown_evt;

    // Reason chooser; a commanded turn-off is not a fault and records nothing
    always_comb begin
        shutdown_reason_next = shutdown_reason_reg;
        if (clear_status) begin
            shutdown_reason_next = hotswap_fault_pkg::CAUSE_NONE;
        end
        // Shutdown wins over a clear; voltage faults rank above the others
        if (overvolt_shutdown_evt) begin
            shutdown_reason_next = hotswap_fault_pkg::CAUSE_OVERVOLT;
        end else if (undervolt_shutdown_evt) begin
            shutdown_reason_next = hotswap_fault_pkg::CAUSE_UNDERVOLT;
        end else if (pass_health_shutdown_evt) begin
            shutdown_reason_next = hotswap_fault_pkg::CAUSE_PASS_HEALTH;
        end else if (timed_oc_shutdown_evt) begin
            shutdown_reason_next = hotswap_fault_pkg::CAUSE_TIMED_OC;
        end else if (overtemp_shutdown_evt) begin
            shutdown_reason_next = hotswap_fault_pkg::CAUSE_OVERTEMP;
        end
    end

    // Reason register holds until a status clear or a new shutdown pulse
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            shutdown_reason_reg <= hotswap_fault_pkg::CAUSE_NONE;
        end else if (ce) begin
            shutdown_reason_reg <= shutdown_reason_next;
        end
    end

    // Communication register image; reserved bits stay zero
    always_comb begin
        comm_memory_fault_status = hotswap_fault_pkg::COMM_FAULT_RESET;
        comm_memory_fault_status[hotswap_fault_pkg::BIT_BAD_COMMAND] = comm_bus.flags[4];
        comm_memory_fault_status[hotswap_fault_pkg::BIT_BAD_PAYLOAD] = comm_bus.flags[3];
        comm_memory_fault_status[hotswap_fault_pkg::BIT_PACKET_CHECK] = comm_bus.flags[2];
        comm_memory_fault_status[hotswap_fault_pkg::BIT_TRIM_STORE] = comm_bus.flags[1];
        comm_memory_fault_status[hotswap_fault_pkg::BIT_MISC_BUS] = comm_bus.flags[0];
    end

    // Vendor register image; comparator bits are live, not latched
    always_comb begin
        vendor_fault_status = hotswap_fault_pkg::VENDOR_FAULT_RESET;
        vendor_fault_status[hotswap_fault_pkg::BIT_PASS_HEALTH] = vendor_bus.flags[2];
        vendor_fault_status[hotswap_fault_pkg::BIT_UV_LIVE] =
            undervoltage_comparator_live;
        vendor_fault_status[hotswap_fault_pkg::BIT_OV_LIVE] =
            overvoltage_comparator_live;
        vendor_fault_status[hotswap_fault_pkg::BIT_SHORT_CIRCUIT] = vendor_bus.flags[1];
        vendor_fault_status[hotswap_fault_pkg::BIT_CURRENT_LIMIT] = vendor_bus.flags[0];
        vendor_fault_status[hotswap_fault_pkg::CAUSE_MSB:0] = shutdown_reason_reg;
    end

    // Read decode; anything else answers zero and changes nothing
    always_comb begin
        unique case (rd_cmd)
            hotswap_fault_pkg::CMD_COMM_FAULT: begin
                rd_data_next = comm_memory_fault_status;
            end
            hotswap_fault_pkg::CMD_VENDOR_FAULT: begin
                rd_data_next = vendor_fault_status;
            end
            default: begin
                rd_data_next = hotswap_fault_pkg::UNMAPPED_READ;
            end
        endcase
    end

    // Read answer one cycle after the request, valid for one cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_data <= hotswap_fault_pkg::UNMAPPED_READ;
            rd_valid <= 1'b0;
        end else if (ce) begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= rd_data_next;
            end
        end
    end

    // Gate is refused the same edge a trim fault lands, and stays refused until a status clear
    assign gate_drive_next = gate_request_live & ~comm_bus.flags[1] &
                             ~trim_store_corrupt_evt;

    // Registered gate permission; trim fault survives only until cleared
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gate_drive_en <= 1'b0;
        end else if (ce) begin
            gate_drive_en <= gate_drive_next;
        end
    end

    // Stable pin level for three enabled cycles
    sequence s_uv_high;
        (ce && uv_comparator_pin) [*3];
    endsequence

    sequence s_uv_low;
        (ce && !uv_comparator_pin) [*3];
    endsequence

    sequence s_ov_high;
        (ce && ov_comparator_pin) [*3];
    endsequence

    sequence s_short_high;
        (ce && short_circuit_pin) [*3];
    endsequence

    property p_bad_command;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && bad_command_evt) |=> comm_memory_fault_status[7];
    endproperty
    a_bad_command: assert property (p_bad_command) else $error("bad command not latched");

    property p_payload_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        (comm_memory_fault_status[6] && !clear_status) |=> comm_memory_fault_status[6];
    endproperty
    a_payload_hold: assert property (p_payload_hold) else $error("payload flag lost");

    property p_check_set_wins;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && packet_check_evt && clear_status) |=> comm_memory_fault_status[5];
    endproperty
    a_check_set_wins: assert property (p_check_set_wins) else $error("check flag lost");

    property p_trim_gate;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && trim_store_corrupt_evt) |=> (comm_memory_fault_status[4] && !gate_drive_en);
    endproperty
    a_trim_gate: assert property (p_trim_gate) else $error("gate on with trim fault");

    property p_misc_bus;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && misc_bus_evt) |=> comm_memory_fault_status[1];
    endproperty
    a_misc_bus: assert property (p_misc_bus) else $error("misc bus fault not latched");

    property p_reset_zero;
        @(posedge clk_sys)
        sys_rst |=> (vendor_fault_status == 8'h00 && comm_memory_fault_status == 8'h00);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("status not zero after reset");

    property p_vendor_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && rd_en && rd_cmd == 8'h80) |=> (rd_valid && rd_data == $past(vendor_fault_status));
    endproperty
    a_vendor_read: assert property (p_vendor_read) else $error("vendor read wrong");

    property p_uv_live;
        @(posedge clk_sys) disable iff (sys_rst)
        (s_uv_high |-> vendor_fault_status[6]) and (s_uv_low |-> !vendor_fault_status[6]);
    endproperty
    a_uv_live: assert property (p_uv_live) else $error("uv bit not live");

    property p_ov_live;
        @(posedge clk_sys) disable iff (sys_rst)
        s_ov_high |-> vendor_fault_status[5];
    endproperty
    a_ov_live: assert property (p_ov_live) else $error("ov bit not live");

    property p_short_circuit;
        @(posedge clk_sys) disable iff (sys_rst)
        s_short_high |=> vendor_fault_status[4];
    endproperty
    a_short_circuit: assert property (p_short_circuit) else $error("short not latched");

    property p_limit_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        (vendor_fault_status[3] && !clear_status) |=> vendor_fault_status[3];
    endproperty
    a_limit_hold: assert property (p_limit_hold) else $error("limit flag lost");

    property p_reason_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        (!any_shutdown && !clear_status) |=> $stable(vendor_fault_status[2:0]);
    endproperty
    a_reason_hold: assert property (p_reason_hold) else $error("reason changed");

    property p_timed_oc;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && timed_oc_shutdown_evt && !overvolt_shutdown_evt && !undervolt_shutdown_evt
            && !pass_health_shutdown_evt) |=> vendor_fault_status[2:0] == 3'h2;
    endproperty
    a_timed_oc: assert property (p_timed_oc) else $error("timed oc reason wrong");

    property p_overvolt;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && overvolt_shutdown_evt) |=> vendor_fault_status[2:0] == 3'h6;
    endproperty
    a_overvolt: assert property (p_overvolt) else $error("overvolt reason wrong");

    property p_clear_all;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && clear_status && !any_shutdown && comm_bus.set_evt == '0
            && vendor_bus.set_evt == '0)
        |=> (comm_memory_fault_status == 8'h00 && vendor_fault_status[4:0] == 5'h00
            && !vendor_fault_status[7]);
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("clear incomplete");

    property p_unmapped;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && rd_en && rd_cmd != 8'h80 && rd_cmd != 8'h7E) |=> rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// ### logic/hotswap_fault_pkg.sv
// Constants shared by the hot-swap fault status register bank
package hotswap_fault_pkg;
    // Command codes at which the two status registers answer
    localparam logic [7:0] CMD_COMM_FAULT = 8'h7E;
    localparam logic [7:0] CMD_VENDOR_FAULT = 8'h80;
    // Values after reset
    localparam logic [7:0] COMM_FAULT_RESET = 8'h00;
    localparam logic [7:0] VENDOR_FAULT_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Field positions in the communication fault register
    localparam int BIT_BAD_COMMAND = 7;
    localparam int BIT_BAD_PAYLOAD = 6;
    localparam int BIT_PACKET_CHECK = 5;
    localparam int BIT_TRIM_STORE = 4;
    localparam int BIT_MISC_BUS = 1;
    // Field positions in the vendor fault register
    localparam int BIT_PASS_HEALTH = 7;
    localparam int BIT_UV_LIVE = 6;
    localparam int BIT_OV_LIVE = 5;
    localparam int BIT_SHORT_CIRCUIT = 4;
    localparam int BIT_CURRENT_LIMIT = 3;
    localparam int CAUSE_MSB = 2;
    // Encodings of the last shutdown reason field
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_OVERTEMP = 3'h1;
    localparam logic [2:0] CAUSE_TIMED_OC = 3'h2;
    localparam logic [2:0] CAUSE_PASS_HEALTH = 3'h3;
    localparam logic [2:0] CAUSE_UNDERVOLT = 3'h4;
    localparam logic [2:0] CAUSE_OVERVOLT = 3'h6;
    // Sticky flag counts per register
    localparam int COMM_FLAG_COUNT = 5;
    localparam int VENDOR_FLAG_COUNT = 3;
    // Pin inputs passed through the synchroniser
    localparam int PIN_COUNT = 6;
endpackage

// ### logic/fault_flag_if.sv
// Carrier between the register logic and a bank of sticky fault flags
`timescale 1ns/1ps
interface fault_flag_if #(parameter int N = 1);
    logic [N-1:0] set_evt; // Set requests, one-cycle pulses or levels held high
    logic clear; // Clear all flags of the bank
    logic [N-1:0] flags; // Present flag values
    modport bank(input set_evt, input clear, output flags);
    modport user(output set_evt, output clear, input flags);
endinterface

// ### logic/sticky_bank.sv
// Bank of sticky flags where a set wins over a clear in the same cycle
`timescale 1ns/1ps
module sticky_bank #(
    parameter int N = 1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    fault_flag_if.bank flag_bus
);
    logic [N-1:0] flags_reg; // Latched flags

    // Set has priority so an event landing on a clear is never lost
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flags_reg <= '0;
        end else if (ce) begin
            flags_reg <= flag_bus.set_evt | (flags_reg & {N{~flag_bus.clear}});
        end
    end

    assign flag_bus.flags = flags_reg;
endmodule

// ### logic/sync2.sv
// Two-stage synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1_reg; // Read by the second stage only
    logic [W-1:0] stage2_reg; // Safe to use downstream

    // Both stages freeze with the clock enable, like the rest of the block
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else if (ce) begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule

// ### verif/status_host_model.sv
// Bus host model that issues register reads toward the status bank
`timescale 1ns/1ps
module status_host_model (
    input wire logic clk_sys,
    output logic rd_en,
    output logic [7:0] rd_cmd
);
    // Idle at time zero, no read pending
    initial begin
        rd_en = 1'b0;
        rd_cmd = 8'h00;
    end

    // Raise one read; the caller sits at a rising edge and calls once per edge
    task automatic issue(input logic [7:0] cmd);
        rd_en <= 1'b1;
        rd_cmd <= cmd; // Reads only, the host never offers a write
    endtask

    // Drop the request; the code turns over so a stale code never looks valid
    task automatic idle();
        rd_en <= 1'b0;
        rd_cmd <= ~rd_cmd;
    endtask
endmodule

// ### verif/tb_hotswap_fault_status_regs.sv
// Self-checking bench for the hot-swap fault status register bank
`timescale 1ns/1ps
module tb_hotswap_fault_status_regs;
    logic clk_sys = 1'b0; // 40 MHz system clock
    logic sys_rst = 1'b1; // Held high for the first cycles
    logic ce = 1'b1; // Clock enable
    logic clear_status = 1'b0; // Clear pulse
    logic [4:0] comm_evt = 5'h00; // Command, payload, check, misc, trim events
    logic [4:0] cause_evt = 5'h00; // Overtemp, timed OC, health, undervolt, overvolt
    logic [4:0] pins = 5'h00; // Health, short, limit, UV and OV levels
    logic gate_req = 1'b1; // Gate drive request level
    logic rd_en;
    logic [7:0] rd_cmd;
    logic [7:0] rd_data;
    logic rd_valid;
    logic gate_drive_en;
    logic [7:0] exp_q[$]; // Expected answers, oldest first
    logic [7:0] comm_e = 8'h00; // Expected communication image
    logic [7:0] vend_e = 8'h00; // Expected vendor image without live bits
    int n_fail = 0;
    int compares = 0;
    logic [31:0] rnd;

    // Clock, 25 ns period
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    status_host_model host (.clk_sys(clk_sys), .rd_en(rd_en), .rd_cmd(rd_cmd));

    hotswap_fault_status_regs uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
        .rd_en(rd_en), .rd_cmd(rd_cmd), .rd_data(rd_data), .rd_valid(rd_valid),
        .clear_status(clear_status),
        .bad_command_evt(comm_evt[0]), .bad_payload_evt(comm_evt[1]),
        .packet_check_evt(comm_evt[2]), .misc_bus_evt(comm_evt[3]),
        .trim_store_corrupt_evt(comm_evt[4]),
        .pass_health_pin(pins[0]), .short_circuit_pin(pins[1]),
        .current_limit_pin(pins[2]), .uv_comparator_pin(pins[3]),
        .ov_comparator_pin(pins[4]), .gate_request_pin(gate_req),
        .overtemp_shutdown_evt(cause_evt[0]), .timed_oc_shutdown_evt(cause_evt[1]),
        .pass_health_shutdown_evt(cause_evt[2]), .undervolt_shutdown_evt(cause_evt[3]),
        .overvolt_shutdown_evt(cause_evt[4]), .gate_drive_en(gate_drive_en)
    );

    // Map an event mask onto communication register bits
    function automatic logic [7:0] comm_bits(input logic [4:0] m);
        logic [7:0] b;
        b = 8'h00;
        b[hotswap_fault_pkg::BIT_BAD_COMMAND] = m[0];
        b[hotswap_fault_pkg::BIT_BAD_PAYLOAD] = m[1];
        b[hotswap_fault_pkg::BIT_PACKET_CHECK] = m[2];
        b[hotswap_fault_pkg::BIT_MISC_BUS] = m[3];
        b[hotswap_fault_pkg::BIT_TRIM_STORE] = m[4];
        return b;
    endfunction

    // Map pin levels onto vendor bits; live selects the comparator part only
    function automatic logic [7:0] vend_bits(input logic [4:0] m, input logic live);
        logic [7:0] b;
        b = 8'h00;
        b[hotswap_fault_pkg::BIT_PASS_HEALTH] = m[0] & ~live;
        b[hotswap_fault_pkg::BIT_SHORT_CIRCUIT] = m[1] & ~live;
        b[hotswap_fault_pkg::BIT_CURRENT_LIMIT] = m[2] & ~live;
        b[hotswap_fault_pkg::BIT_UV_LIVE] = m[3] & live;
        b[hotswap_fault_pkg::BIT_OV_LIVE] = m[4] & live;
        return b;
    endfunction

    // Reason code expected for shutdown pulse number i
    function automatic logic [2:0] cause_code(input int i);
        case (i)
            0: return 3'h1;
            1: return 3'h2;
            2: return 3'h3;
            3: return 3'h4;
            default: return 3'h6;
        endcase
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Single comparison point; a mismatch is counted and printed at once
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    // One read, noted in the queue; back to back when called at successive edges
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        exp_q.push_back(exp);
        host.issue(cmd);
        cyc(1);
    endtask

    // Both registers back to back; live bits follow the present pin levels
    task automatic rd_both();
        rd(hotswap_fault_pkg::CMD_COMM_FAULT, comm_e);
        rd(hotswap_fault_pkg::CMD_VENDOR_FAULT, vend_e | vend_bits(pins, 1'b1));
        host.idle();
        cyc(1);
    endtask

    // One-cycle pulse of events and clear together, so set-versus-clear is exercised
    task automatic pulse(input logic [4:0] cm, input logic [4:0] cs, input logic clr);
        comm_evt <= cm;
        cause_evt <= cs;
        clear_status <= clr;
        cyc(1);
        comm_evt <= 5'h00;
        cause_evt <= 5'h00;
        clear_status <= 1'b0;
    endtask

    task automatic report_and_stop();
        if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Answer watcher: every answer takes the oldest note off the queue
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() > 0) begin
                check(rd_data, exp_q.pop_front());
            end else begin
                n_fail++;
                $display("[FAIL] %0t ns answer with no read pending", $time);
            end
        end
    end

    // Watchdog well beyond the expected run of under a thousand cycles
    initial begin
        cyc(4000);
        n_fail++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        rnd = $urandom(9);
        cyc(5);
        sys_rst <= 1'b0;
        cyc(2);
        rd(8'h81, hotswap_fault_pkg::UNMAPPED_READ);
        rd_both();
        check({7'h00, gate_drive_en}, 8'h01);
        // Random bus events, some with a clear in the same cycle where the set must win
        for (int i = 0; i < 8; i++) begin
            // First pass raises every event together with a clear
            rnd = (i == 0) ? 32'h3F : $urandom;
            if (rnd[5]) comm_e = 8'h00;
            comm_e = comm_e | comm_bits(rnd[4:0]);
            pulse(rnd[4:0], 5'h00, rnd[5]);
            rd_both();
            cyc(2);
            check({7'h00, gate_drive_en}, {7'h00, ~comm_e[4]});
        end
        pulse(5'h00, 5'h00, 1'b1);
        comm_e = 8'h00;
        rd_both();
        // Events while the clock enable is low leave no trace
        ce <= 1'b0;
        pulse(5'h1F, 5'h1F, 1'b0);
        ce <= 1'b1;
        rd_both();
        // Random pin levels: sticky bits latch, comparator bits follow the pins
        for (int i = 0; i < 6; i++) begin
            rnd = (i == 0) ? 32'h7F : $urandom;
            pins <= rnd[4:0];
            vend_e = vend_e | vend_bits(rnd[4:0], 1'b0);
            cyc(4);
            rd_both();
            pins <= {rnd[4:3], 3'b000};
            cyc(4);
            if (rnd[6]) begin
                vend_e = 8'h00;
                pulse(5'h00, 5'h00, 1'b1);
            end
            rd_both();
        end
        pins <= 5'h00;
        cyc(4);
        vend_e = 8'h00;
        pulse(5'h00, 5'h00, 1'b1);
        rd_both();
        // Every shutdown reason, then all at once together with a clear
        for (int i = 0; i < 5; i++) begin
            pulse(5'h00, 5'h01 << i, 1'b0);
            vend_e = {5'h00, cause_code(i)};
            rd_both();
        end
        pulse(5'h00, 5'h1F, 1'b1);
        vend_e = {5'h00, hotswap_fault_pkg::CAUSE_OVERVOLT};
        rd_both();
        pulse(5'h00, 5'h00, 1'b1);
        vend_e = 8'h00;
        rd_both();
        // Second reset in mid-run after latching every bus event and the overtemp reason
        pulse(5'h1F, 5'h01, 1'b0);
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        comm_e = 8'h00;
        cyc(2);
        rd_both();
        check({7'h00, gate_drive_en}, 8'h01);
        gate_req <= 1'b0;
        cyc(5);
        check({7'h00, gate_drive_en}, 8'h00);
        cyc(3);
        check(8'(exp_q.size()), 8'h00);
        report_and_stop();
    end
endmodule
